// File: include/lbam_defs.svh
// Purpose: constants for the leaky bucket activity monitor
// Assumes: 50 MHz aclk
// Notes: offsets are byte addresses on the register bus
`ifndef LBAM_DEFS_SVH
`define LBAM_DEFS_SVH
`define LBAM_CLK_HZ 50000000
`define LBAM_CYCLE_MS 128
`define LBAM_CYCLE_CLKS ((`LBAM_CLK_HZ / 1000) * `LBAM_CYCLE_MS)
`define LBAM_OFF_RATE 8'h00
`define LBAM_OFF_ACC 8'h04
`define LBAM_OFF_STAT 8'h08
`define LBAM_OFF_CLR 8'h0c
`define LBAM_OFF_IEN 8'h10
`define LBAM_RATE_RST 8'h01
`define LBAM_ACC_MAX 8'hff
`define LBAM_RESP_OK 2'b00
`define LBAM_RESP_ERR 2'b10
`define LBAM_ST_INC 0
`define LBAM_ST_DEC 1
`define LBAM_ST_CYC 2
`endif

// File: include/lbam_pkg.sv
// Purpose: types for the leaky bucket activity monitor
// Assumes: lbam_defs.svh constants
// Notes: state is one packed struct
package lbam_pkg;
    typedef struct packed {
        logic [31:0] tick_cnt;
        logic bad_seen;
        logic [3:0] clean_cnt;
        logic [7:0] acc;
        logic [7:0] rate;
        logic [2:0] stat;
        logic [2:0] ien;
        logic aw_done;
        logic w_done;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lbam_state_t;
endpackage

// File: src/lbam_monitor.sv
// Purpose: leaky bucket accumulator for input activity monitoring
// Assumes: fail and erratic inputs synchronous to aclk
// Notes: registers reached over AXI4-Lite
// Summary of operation
// - judge input activity once per 128 ms observation cycle
// - each failed or erratic cycle raises the accumulator by one, holding at 255
// - each clean run of 1, 2, 4 or 8 cycles lowers it by one, holding at zero
// - decay rate equals fill rate, or one half, quarter or eighth
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "lbam_defs.svh"
module lbam_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // monitored input status
    input wire logic in_fail,
    input wire logic in_erratic,
    // accumulator and interrupt
    output logic [7:0] bucket_level,
    output logic cycle_tick,
    output logic irq,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    lbam_pkg::lbam_state_t s_q, s_d;
    logic tick, bad, clean_done, wr_go;
    logic [3:0] period;
    logic [2:0] ev, clr;

    // clean-cycle period from rate field
    always_comb begin
        case (s_q.rate[1:0])
            2'b00: period = 4'h1;
            2'b01: period = 4'h2;
            2'b10: period = 4'h4;
            2'b11: period = 4'h8;
            default: period = 4'h1;
        endcase
    end

    assign tick = (s_q.tick_cnt == 32'(`LBAM_CYCLE_CLKS - 1));
    assign bad = s_q.bad_seen | in_fail | in_erratic;
    assign clean_done = tick && !bad && (s_q.clean_cnt + 4'h1 >= period);
    assign wr_go = s_q.aw_done && s_q.w_done && !s_q.bvalid;
    assign s_axi_awready = !s_q.aw_done && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_done && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;

    always_comb begin
        s_d = s_q;
        ev = 3'h0;
        clr = 3'h0;
        // observation cycle timer and activity latch
        if (tick) begin
            s_d.tick_cnt = 32'h0;
            s_d.bad_seen = 1'b0;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 32'h1;
            s_d.bad_seen = bad;
        end
        if (tick) begin
            ev[`LBAM_ST_CYC] = 1'b1;
            if (bad) begin
                s_d.clean_cnt = 4'h0;
                if (s_q.acc != `LBAM_ACC_MAX) begin
                    s_d.acc = s_q.acc + 8'h1;
                end
                ev[`LBAM_ST_INC] = 1'b1;
            end else if (clean_done) begin
                s_d.clean_cnt = 4'h0;
                if (s_q.acc != 8'h00) begin
                    s_d.acc = s_q.acc - 8'h1;
                    ev[`LBAM_ST_DEC] = 1'b1;
                end
            end else begin
                s_d.clean_cnt = s_q.clean_cnt + 4'h1;
            end
        end
        // write channel capture
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_done = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_done = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            s_d.aw_done = 1'b0;
            s_d.w_done = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = `LBAM_RESP_OK;
            case ({s_q.awaddr[7:2], 2'b00})
                `LBAM_OFF_RATE: begin
                    if (s_q.wstrb[0]) begin
                        s_d.rate = s_q.wdata[7:0];
                        s_d.clean_cnt = 4'h0;
                    end
                end
                `LBAM_OFF_CLR: begin
                    if (s_q.wstrb[0]) begin
                        clr = s_q.wdata[2:0];
                    end
                end
                `LBAM_OFF_IEN: begin
                    if (s_q.wstrb[0]) begin
                        s_d.ien = s_q.wdata[2:0];
                    end
                end
                `LBAM_OFF_ACC, `LBAM_OFF_STAT: begin
                    s_d.bresp = `LBAM_RESP_OK;
                end
                default: s_d.bresp = `LBAM_RESP_ERR;
            endcase
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // sticky status: set wins over clear
        s_d.stat = (s_q.stat & ~clr) | ev;
        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = `LBAM_RESP_OK;
            case ({s_axi_araddr[7:2], 2'b00})
                `LBAM_OFF_RATE: s_d.rdata = {24'h0, s_q.rate};
                `LBAM_OFF_ACC: s_d.rdata = {24'h0, s_q.acc};
                `LBAM_OFF_STAT: s_d.rdata = {29'h0, s_q.stat};
                `LBAM_OFF_CLR: s_d.rdata = 32'h0;
                `LBAM_OFF_IEN: s_d.rdata = {29'h0, s_q.ien};
                default: begin
                    s_d.rdata = 32'h0;
                    s_d.rresp = `LBAM_RESP_ERR;
                end
            endcase
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
            s_q.rate <= `LBAM_RATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign bucket_level = s_q.acc;
    assign cycle_tick = tick;
    assign irq = |(s_q.stat & s_q.ien);
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // properties share the bus clock and reset
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // observation cycle timer
    a_cycle_period: assert property (
        s_q.tick_cnt < 32'(`LBAM_CYCLE_CLKS))
        else $error("cycle counter past its period");
    a_cycle_count: assert property (
        s_q.tick_cnt != 32'h0 |->
            s_q.tick_cnt == $past(s_q.tick_cnt) + 32'h1)
        else $error("cycle counter skipped a clock");
    a_cycle_restart: assert property (
        tick |=> s_q.tick_cnt == 32'h0 && !s_q.bad_seen)
        else $error("cycle did not restart");

    // bucket steps
    a_fill_step: assert property (
        tick && bad && s_q.acc != `LBAM_ACC_MAX |=>
            s_q.acc == $past(s_q.acc) + 8'h1)
        else $error("fill step wrong");
    a_leak_step: assert property (
        clean_done && s_q.acc != 8'h0 |=> s_q.acc == $past(s_q.acc) - 8'h1)
        else $error("leak step wrong");
    a_hold_between: assert property (
        !tick |=> s_q.acc == $past(s_q.acc))
        else $error("accumulator moved off tick");
    a_clean_bound: assert property (
        s_q.clean_cnt < period)
        else $error("clean run exceeds period");
    a_rate_map: assert property (
        period == (4'h1 << s_q.rate[1:0]))
        else $error("rate decode wrong");
    a_no_leak_bad: assert property (
        tick && bad |=> s_q.clean_cnt == 4'h0 && s_q.stat[0])
        else $error("bad cycle not counted");
    a_irq_level: assert property (
        $rose(irq) |-> $past(ev) != 3'h0 || $past(wr_go))
        else $error("irq rose without event or enable write");

    // register bus holds its answers until taken
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=>
            s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");

    // main scenarios
    c_fill: cover property (tick && bad);
    c_leak: cover property (clean_done && s_q.acc != 8'h0);
    c_slow: cover property (clean_done && period == 4'h8);
    c_full: cover property (tick && bad && s_q.acc == `LBAM_ACC_MAX);
endmodule

// File: verif/lbam_monitor_test.sv
// Purpose: register bus and mid-cycle checks of the activity monitor
// Assumes: 50 MHz aclk, observation cycle left at its full length
// Notes: the run is far shorter than one cycle, so no tick may appear
`timescale 1ns/1ns
`include "lbam_defs.svh"
module lbam_monitor_test;
    logic aclk = 0, aresetn = 0, in_fail = 0, in_erratic = 0;
    logic [7:0] awaddr = 0, araddr = 0, level;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata, got;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, tick, irq, seen = 0;
    logic [1:0] bresp, rresp, resp;
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #10 aclk = ~aclk;
    lbam_monitor lbam_monitor_i (.aclk(aclk), .aresetn(aresetn),
        .in_fail(in_fail), .in_erratic(in_erratic), .bucket_level(level),
        .cycle_tick(tick), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        b = 0;
        while (!b) begin
            @(negedge aclk);
            aw = awvalid && awready; w = wvalid && wready;
            b = bvalid; resp = bresp;
            @(posedge aclk);
            if (aw) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
            if (b) bready <= 1'h0;
        end
    endtask
    task rd(input logic [7:0] a);
        logic ar, r;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        r = 0;
        while (!r) begin
            @(negedge aclk);
            ar = arvalid && arready; r = rvalid;
            got = rdata; resp = rresp;
            @(posedge aclk);
            if (ar) arvalid <= 1'h0;
            if (r) rready <= 1'h0;
        end
    endtask
    // any tick, level change or interrupt before a full cycle is wrong
    always @(negedge aclk) begin
        if (aresetn && (tick !== 1'h0 || level !== 8'h00 || irq !== 1'h0))
            seen = 1'h1;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`LBAM_OFF_RATE); cmp(got, 32'h1);
        rd(`LBAM_OFF_ACC); cmp(got, 32'h0);
        rd(`LBAM_OFF_STAT); cmp(got, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(`LBAM_OFF_RATE, 32'hfc | 32'(i)); cmp(32'(resp), 32'h0);
            rd(`LBAM_OFF_RATE); cmp(got, 32'hfc | 32'(i));
        end
        wr(8'h14, 32'h3); cmp(32'(resp), 32'h2);
        rd(8'h14); cmp(got, 32'h0);
        cmp(32'(resp), 32'h2);
        wr(`LBAM_OFF_IEN, 32'h7);
        rd(`LBAM_OFF_IEN); cmp(got, 32'h7);
        // failures well inside the first cycle must not move the bucket
        in_fail <= 1'h1;
        repeat (20000) @(posedge aclk);
        in_fail <= 1'h0;
        in_erratic <= 1'h1;
        repeat (20000) @(posedge aclk);
        // cycle timer counts every clock since reset release
        cmp(lbam_monitor_i.s_q.tick_cnt + 32'h8, 32'(cyc));
        wr(`LBAM_OFF_CLR, 32'h7); cmp(32'(resp), 32'h0);
        rd(`LBAM_OFF_ACC); cmp(got, 32'h0);
        rd(`LBAM_OFF_STAT); cmp(got, 32'h0);
        // a reset mid-run restores the defaults
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`LBAM_OFF_RATE); cmp(got, 32'(`LBAM_RATE_RST));
        rd(`LBAM_OFF_IEN); cmp(got, 32'h0);
        rd(`LBAM_OFF_ACC); cmp(got, 32'h0);
        cmp(32'(seen), 32'h0);
        tally_and_finish;
    end
endmodule
